// ### src/tps_tmr.sv
// Purpose: pin routing, a/d triggers, irq merge and count stop control
// Assumes: timer core events are one-cycle pulses on this clock
// Notes:   port pins pass three flops before use
//
// Functional notes
// - channel 0 select bits route pins to port bits 0-3
// - channel 1 select bits route pins to port bits 4-7
// - select registers reset zero, unassigned bits read zero
// - software sets pin select before other registers
// - software leaves pin select alone while running
// - every compare match can start a conversion
// - trigger select register picks forwarded matches
// - six sources merge into one request per channel
// - acceptance uses mask, flag and priority levels
// - enabled set status bit raises request flag
// - flag falls once no enabled status remains
// - flag holds while another enabled source stands
// - acknowledge leaves status, handler clears it
// - stop-select zero ignores run-bit clear writes
// - same-write select set and clear does not stop
// - software stop holds pin levels before stop
// - match-a stop holds level after match change
// - pwm modes drive initial levels when stopped
`timescale 1ns/100ps
module tps_tmr
  import tps_pkg::*;
#(
  parameter int NSRC = TPS_SRC
)
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  tps_link_if.tmr                link,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [TPS_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic [7:0]        match_evt,
  input  wire logic [1:0]        ovf_evt,
  input  wire logic [1:0]        udf_evt,
  input  wire logic [7:0]        wave_out,
  input  wire logic [7:0]        wave_oe,
  output logic      [1:0]        count_run,
  output logic      [7:0]        pin_to_core,
  input  wire logic [7:0]        p2_in,
  output logic      [7:0]        p2_out,
  output logic      [7:0]        p2_oe
);
  logic [7:0]      psr0_r;
  logic [7:0]      psr1_r;
  logic [7:0]      adcsel_r;
  logic [NSRC-1:0] stat_r [TPS_CH];
  logic [NSRC-1:0] stat_nxt [TPS_CH];
  logic [NSRC-1:0] ien_r [TPS_CH];
  logic [NSRC-1:0] ien_nxt [TPS_CH];
  logic [NSRC-1:0] src_evt [TPS_CH];
  logic [1:0]      run_r;
  logic [1:0]      run_nxt;
  logic [1:0]      ssel_r;
  logic [3:0]      fcr_r;
  logic [7:0]      hold_r;
  logic [7:0]      p2_s1_r;
  logic [7:0]      p2_s2_r;
  logic [7:0]      route;
  logic [1:0]      req;
  logic            setup;
  logic            wr_go;
  logic            rd_go;
  logic            pwm_mode;

  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pready & pwrite;
  assign rd_go = psel & penable & pready & ~pwrite;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // read data latched in setup, answer in the first access cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= TPS_ZERO;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= TPS_ZERO;
      if (setup) begin
        case (paddr)
          {TPS_PSR0_IDX[9:0], 2'b00}: prdata[7:0] <= psr0_r;
          {TPS_PSR1_IDX[9:0], 2'b00}: prdata[7:0] <= psr1_r;
          TPS_ADCSEL_A: prdata[7:0] <= adcsel_r;
          TPS_STAT0_A:  prdata[NSRC-1:0] <= stat_r[0];
          TPS_STAT1_A:  prdata[NSRC-1:0] <= stat_r[1];
          TPS_IEN0_A:   prdata[NSRC-1:0] <= ien_r[0];
          TPS_IEN1_A:   prdata[NSRC-1:0] <= ien_r[1];
          TPS_START_A:  prdata[3:0] <= {ssel_r, run_r};
          TPS_FCR_A:    prdata[3:0] <= fcr_r;
          default:      pslverr <= 1'b1;
        endcase
      end
    end
  end

  // pin select, trigger select and function control registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      psr0_r   <= TPS_PSR_RST;
      psr1_r   <= TPS_PSR_RST;
      adcsel_r <= 8'h00;
      fcr_r    <= 4'h0;
    end else if (clk_en && wr_go) begin
      case (paddr)
        {TPS_PSR0_IDX[9:0], 2'b00}:
          psr0_r <= pwdata[7:0] & TPS_PSR0_MASK;
        {TPS_PSR1_IDX[9:0], 2'b00}:
          psr1_r <= pwdata[7:0] & TPS_PSR1_MASK;
        TPS_ADCSEL_A: adcsel_r <= pwdata[7:0];
        TPS_FCR_A:    fcr_r    <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status and interrupt merge
  // ----------------------------------------------------------------
  // six sources: four matches, overflow, underflow
  always_comb begin
    for (int c = 0; c < TPS_CH; c++) begin
      src_evt[c] = '0;
      src_evt[c][3:0] = match_evt[c*4 +: 4];
      src_evt[c][TPS_OVF_POS] = ovf_evt[c];
      src_evt[c][TPS_UDF_POS] = udf_evt[c];
    end
  end

  // read clears only the bits it reported, a new event wins
  always_comb begin
    for (int c = 0; c < TPS_CH; c++) begin
      stat_nxt[c] = stat_r[c];
      ien_nxt[c]  = ien_r[c];
    end
    if (rd_go && paddr == TPS_STAT0_A) begin
      stat_nxt[0] = stat_r[0] & ~prdata[NSRC-1:0];  // setup snapshot
    end
    if (rd_go && paddr == TPS_STAT1_A) begin
      stat_nxt[1] = stat_r[1] & ~prdata[NSRC-1:0];
    end
    if (wr_go && paddr == TPS_IEN0_A) begin
      ien_nxt[0] = pwdata[NSRC-1:0];
    end
    if (wr_go && paddr == TPS_IEN1_A) begin
      ien_nxt[1] = pwdata[NSRC-1:0];
    end
    for (int c = 0; c < TPS_CH; c++) begin
      stat_nxt[c] = stat_nxt[c] | src_evt[c];
    end
  end

  // request level follows status and enables, no latch
  always_comb begin
    for (int c = 0; c < TPS_CH; c++) begin
      req[c] = |(stat_nxt[c] & ien_nxt[c]);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < TPS_CH; c++) begin
        stat_r[c] <= '0;
        ien_r[c]  <= '0;
      end
      link.irq_req <= 2'b00;
      irq          <= 1'b0;
    end else if (clk_en) begin
      stat_r       <= stat_nxt;
      ien_r        <= ien_nxt;
      link.irq_req <= req;
      irq          <= |req;
    end
  end

  // selected compare matches start a conversion
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      link.adc_trig <= 1'b0;
    end else if (clk_en) begin
      link.adc_trig <= |(match_evt & adcsel_r);
    end
  end

  // ----------------------------------------------------------------
  // count start and stop
  // ----------------------------------------------------------------
  // clearing a run bit acts only when stop-select was already set
  always_comb begin
    run_nxt = run_r;
    for (int c = 0; c < TPS_CH; c++) begin
      if (!ssel_r[c] && match_evt[c*4] && run_r[c]) begin
        run_nxt[c] = 1'b0;
      end
      if (wr_go && paddr == TPS_START_A) begin
        if (pwdata[TPS_RUN_POS+c]) begin
          run_nxt[c] = 1'b1;
        end else if (ssel_r[c]) begin
          run_nxt[c] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run_r     <= 2'b00;
      ssel_r    <= 2'b00;
      count_run <= 2'b00;
    end else if (clk_en) begin
      run_r     <= run_nxt;
      count_run <= run_nxt;
      if (wr_go && paddr == TPS_START_A) begin
        ssel_r <= pwdata[TPS_SEL_POS +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // select bit 2j of each register routes pin j
  generate
    for (genvar j = 0; j < TPS_PINS; j++) begin : g_route
      assign route[j]          = psr0_r[2*j];
      assign route[TPS_PINS+j] = psr1_r[2*j];
    end
  endgenerate

  assign pwm_mode = fcr_r[TPS_MODE_POS +: 2] != TPS_MODE_TIMER;

  // level last driven while running is held once stopped
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hold_r <= 8'h00;
    end else if (clk_en) begin
      for (int p = 0; p < 8; p++) begin
        if (run_r[p/TPS_PINS]) begin
          hold_r[p] <= wave_out[p];
        end
      end
    end
  end

  // drive routed pins only; stopped pwm pins show initial levels
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      p2_out <= 8'h00;
      p2_oe  <= 8'h00;
    end else if (clk_en) begin
      for (int p = 0; p < 8; p++) begin
        p2_oe[p] <= route[p] & wave_oe[p];
        if (run_nxt[p/TPS_PINS]) begin
          p2_out[p] <= wave_out[p];
        end else if (pwm_mode) begin
          p2_out[p] <= (p % 2 == 0) ? fcr_r[TPS_OLSP_POS]
                                    : fcr_r[TPS_OLSN_POS];
        end else begin
          p2_out[p] <= hold_r[p];
        end
      end
    end
  end

  // port inputs pass three flops, unrouted pins read as zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      p2_s1_r     <= 8'h00;
      p2_s2_r     <= 8'h00;
      pin_to_core <= 8'h00;
    end else if (clk_en) begin
      p2_s1_r     <= p2_in;
      p2_s2_r     <= p2_s1_r;
      pin_to_core <= p2_s2_r & route;
    end
  end
endmodule

// ### shared/tps_pkg.sv
// Purpose: shared constants for the timer pin, trigger, irq and stop logic
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   pin-select offsets are indices, byte address is four times them
package tps_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int TPS_CH    = 2;
  localparam int TPS_PINS  = 4;
  localparam int TPS_SRC   = 6;
  localparam int TPS_AW    = 12;
  // ----------------------------------------------------------------
  // timer-side register map (byte addresses, pin-select entries as indices)
  // ----------------------------------------------------------------
  localparam logic [TPS_AW-1:0] TPS_PSR0_IDX  = 12'h184;
  localparam logic [TPS_AW-1:0] TPS_PSR1_IDX  = 12'h185;
  localparam logic [TPS_AW-1:0] TPS_ADCSEL_A  = 12'h000;
  localparam logic [TPS_AW-1:0] TPS_STAT0_A   = 12'h004;
  localparam logic [TPS_AW-1:0] TPS_STAT1_A   = 12'h008;
  localparam logic [TPS_AW-1:0] TPS_IEN0_A    = 12'h00c;
  localparam logic [TPS_AW-1:0] TPS_IEN1_A    = 12'h010;
  localparam logic [TPS_AW-1:0] TPS_START_A   = 12'h014;
  localparam logic [TPS_AW-1:0] TPS_FCR_A     = 12'h018;
  // readable / writable bits of the pin-select registers
  localparam logic [7:0] TPS_PSR0_MASK = 8'h7d;
  localparam logic [7:0] TPS_PSR1_MASK = 8'hf5;
  localparam logic [7:0] TPS_PSR_RST   = 8'h00;
  // count start control layout
  localparam int TPS_RUN_POS  = 0;
  localparam int TPS_SEL_POS  = 2;
  // function control layout
  localparam int TPS_MODE_POS = 0;
  localparam int TPS_OLSP_POS = 2;
  localparam int TPS_OLSN_POS = 3;
  // status bit positions beyond the four match bits
  localparam int TPS_OVF_POS  = 4;
  localparam int TPS_UDF_POS  = 5;
  // ----------------------------------------------------------------
  // controller-side register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [TPS_AW-1:0] TPS_CPU_A    = 12'h000;
  localparam logic [TPS_AW-1:0] TPS_IC0_A    = 12'h004;
  localparam logic [TPS_AW-1:0] TPS_IC1_A    = 12'h008;
  localparam logic [TPS_AW-1:0] TPS_ADCNT_A  = 12'h00c;
  localparam int TPS_IFLAG_POS = 0;
  localparam int TPS_CPL_POS   = 1;
  localparam int TPS_REQ_POS   = 3;
  localparam logic [31:0] TPS_ZERO = 32'h0000_0000;
  // counting modes of the function control register
  typedef enum logic [1:0] {
    TPS_MODE_TIMER, TPS_MODE_RSYNC, TPS_MODE_COMPL_U, TPS_MODE_COMPL_M
  } tps_mode_type;
endpackage

// ### shared/tps_link_if.sv
// Purpose: link between the timer support logic and its controller
// Assumes: both ends on the same clock
// Notes:   no clocking block, plain levels and pulses
`timescale 1ns/100ps
interface tps_link_if;
  logic [1:0] irq_req;   // per-channel request flag level
  logic       adc_trig;  // one-cycle conversion start pulse
  modport tmr (output irq_req, output adc_trig);
  modport ctl (input irq_req, input adc_trig);
endinterface

// ### src/tps_ctl.sv
// Purpose: interrupt acceptance and a/d start logic facing the timer
// Assumes: link signals come from logic on the same clock
// Notes:   acknowledge does not touch the timer status bits
`timescale 1ns/100ps
module tps_ctl
  import tps_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  tps_link_if.ctl                link,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [TPS_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   int_pending,
  output logic                   int_channel,
  output logic      [2:0]        int_level,
  output logic                   adc_start
);
  logic       iflag_r;
  logic [2:0] cpl_r;
  logic [2:0] lvl_r [TPS_CH];
  logic [15:0] adcnt_r;
  logic        wr_go;
  logic        take0;
  logic        take1;

  assign wr_go = psel & penable & pready & pwrite;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // answer in the first access cycle, unmapped reads as zero with error
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= TPS_ZERO;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= TPS_ZERO;
      if (psel & ~penable) begin
        case (paddr)
          TPS_CPU_A:   prdata <= {28'h0, cpl_r, iflag_r};
          TPS_IC0_A:   prdata <= {28'h0, link.irq_req[0], lvl_r[0]};
          TPS_IC1_A:   prdata <= {28'h0, link.irq_req[1], lvl_r[1]};
          TPS_ADCNT_A: prdata <= {16'h0, adcnt_r};
          default:     pslverr <= 1'b1;
        endcase
      end
    end
  end

  // cpu mask and priority registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      iflag_r  <= 1'b0;
      cpl_r    <= 3'h0;
      lvl_r[0] <= 3'h0;
      lvl_r[1] <= 3'h0;
    end else if (clk_en && wr_go) begin
      case (paddr)
        TPS_CPU_A: begin
          iflag_r <= pwdata[TPS_IFLAG_POS];
          cpl_r   <= pwdata[TPS_CPL_POS +: 3];
        end
        TPS_IC0_A: lvl_r[0] <= pwdata[2:0];
        TPS_IC1_A: lvl_r[1] <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // acceptance
  // ----------------------------------------------------------------
  // mask flag, request flag and level above cpu level
  assign take0 = iflag_r & link.irq_req[0] & (lvl_r[0] > cpl_r);
  assign take1 = iflag_r & link.irq_req[1] & (lvl_r[1] > cpl_r);

  // higher level wins, channel 0 on a tie; flag dropping ends it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      int_pending <= 1'b0;
      int_channel <= 1'b0;
      int_level   <= 3'h0;
    end else if (clk_en) begin
      int_pending <= take0 | take1;
      if (take1 && (!take0 || lvl_r[1] > lvl_r[0])) begin
        int_channel <= 1'b1;
        int_level   <= lvl_r[1];
      end else begin
        int_channel <= 1'b0;
        int_level   <= lvl_r[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // a/d start
  // ----------------------------------------------------------------
  // forward each trigger cycle as a start, count them
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      adc_start <= 1'b0;
      adcnt_r   <= 16'h0000;
    end else if (clk_en) begin
      adc_start <= link.adc_trig;
      if (link.adc_trig) begin
        adcnt_r <= adcnt_r + 16'h0001;
      end
    end
  end
endmodule

// ### testbench/tps_link_checker.sv
// Purpose: link and interrupt timing checks for the timer support pair
// Assumes: clk_en held high, link watched on the main clock
// Notes:   instantiated beside the link interface, no bind
`timescale 1ns/100ps
module tps_link_checker (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic [1:0] irq_req,
  input wire logic       adc_trig,
  input wire logic       irq,
  input wire logic [7:0] match_evt,
  input wire logic [1:0] ovf_evt,
  input wire logic [1:0] udf_evt,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       int_pending,
  input wire logic       int_channel,
  input wire logic       adc_start
);
  logic any_match;
  logic bus_acc;
  logic cause0;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // helper causes
  // ----------------------------------------------------------------
  // software access or channel 0 event that may move its flag
  assign any_match = |match_evt;
  assign bus_acc   = psel & penable;
  assign cause0    = (|match_evt[3:0]) | ovf_evt[0] | udf_evt[0] | bus_acc;
  // ----------------------------------------------------------------
  // relations
  // ----------------------------------------------------------------
  a_irq_merge: assert property (irq == (|irq_req))
    else $error("irq differs from or of channel flags");
  a_trig_start: assert property (adc_trig |=> adc_start)
    else $error("conversion start missing after trigger");
  a_start_cause: assert property (adc_start |-> $past(adc_trig))
    else $error("conversion start without trigger");
  a_trig_match: assert property (adc_trig |-> $past(any_match))
    else $error("trigger without compare match");
  a_pend_ch0: assert property (
    int_pending && !int_channel |-> $past(irq_req[0]))
    else $error("channel 0 accepted without request");
  a_pend_ch1: assert property (
    int_pending && int_channel |-> $past(irq_req[1]))
    else $error("channel 1 accepted without request");
  a_flag_source: assert property ($rose(irq_req[0]) |-> $past(cause0))
    else $error("channel 0 flag rose without cause");
  a_flag_drop: assert property ($fell(irq_req[0]) |-> $past(bus_acc))
    else $error("channel 0 flag fell without software access");
  a_pend_idle: assert property (
    (irq_req == 2'b00) [*2] |-> !int_pending)
    else $error("pending with no request flag");
endmodule

// ### testbench/timer_pin_irq_stop_control_test.sv
// Purpose: self-checking bench for timer and controller ends
// Assumes: both apb slaves share address, data and enable lines
// Notes:   random values from a fixed xorshift seed
`timescale 1ns/100ps
module timer_pin_irq_stop_control_test;
  import tps_pkg::*;
  localparam logic [11:0] A_PSR0 = TPS_PSR0_IDX << 2;
  localparam logic [11:0] A_PSR1 = TPS_PSR1_IDX << 2;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        t_psel = 1'b0;
  logic        c_psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] t_prdata, c_prdata, q, r, w;
  logic        t_pready, c_pready, t_pslverr, c_pslverr, e;
  logic        irq, int_pending, int_channel, adc_start;
  logic [2:0]  int_level;
  logic [7:0]  match_evt = 8'h00, wave_out = 8'h00, wave_oe = 8'h00;
  logic [7:0]  p2_in = 8'h00, pin_to_core, p2_out, p2_oe, p0, p1;
  logic [1:0]  ovf_evt = 2'h0, udf_evt = 2'h0, count_run;
  logic [31:0] seed = 32'h4abb3962;
  logic [31:0] cpu_v [4] = '{32'h9, 32'hb, 32'h0, 32'h1};
  int          n_errors = 0;
  int          cmp_count = 0;
  tps_link_if link_i();
  tps_tmr tps_tmr_i (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .link(link_i), .psel(t_psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(t_prdata), .pready(t_pready),
    .pslverr(t_pslverr), .irq(irq), .match_evt(match_evt),
    .ovf_evt(ovf_evt), .udf_evt(udf_evt), .wave_out(wave_out),
    .wave_oe(wave_oe), .count_run(count_run), .pin_to_core(pin_to_core),
    .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe));
  tps_ctl tps_ctl_i (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .link(link_i), .psel(c_psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(c_prdata), .pready(c_pready),
    .pslverr(c_pslverr), .int_pending(int_pending),
    .int_channel(int_channel), .int_level(int_level),
    .adc_start(adc_start));
  tps_link_checker tps_link_checker_i (.clock(clock), .arst_n(arst_n),
    .irq_req(link_i.irq_req), .adc_trig(link_i.adc_trig), .irq(irq),
    .match_evt(match_evt), .ovf_evt(ovf_evt), .udf_evt(udf_evt),
    .psel(t_psel), .penable(penable), .int_pending(int_pending),
    .int_channel(int_channel), .adc_start(adc_start));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // select bits to port pins, pin a lowest
  function automatic logic [7:0] route(input logic [7:0] a, input logic [7:0] b);
    return {b[6], b[4], b[2], b[0], a[6], a[4], a[2], a[0]};
  endfunction
  function automatic logic accept(input logic [31:0] c, input logic [2:0] l);
    return c[0] && (l > c[3:1]);
  endfunction
  // stopped pwm level, even pins positive, odd pins negative
  function automatic logic [3:0] ols(input logic p, input logic n);
    return {n, p, n, p};
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one apb transfer, released at the edge that samples pready
  task automatic apb(input bit c, input bit wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge clock);
    t_psel <= !c;
    c_psel <= c;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while ((c ? c_pready : t_pready) !== 1'b1);
    rd = c ? c_prdata : t_prdata;
    er = c ? c_pslverr : t_pslverr;
    t_psel <= 1'b0;
    c_psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input bit c, input logic [11:0] a, input logic [31:0] d);
    apb(c, 1'b1, a, d, q, e);
  endtask
  task automatic rdc(input string nm, input bit c, input logic [11:0] a,
                     input logic [31:0] ex);
    apb(c, 1'b0, a, 32'h0, q, e);
    chk(nm, ex, q);
  endtask
  // one cycle pulse of source s: 0-3 matches, 4 overflow, 5 underflow
  task automatic pulse(input int ch, input int s);
    @(posedge clock);
    if (s < 4) match_evt[ch*4+s] <= 1'b1;
    else if (s == 4) ovf_evt[ch] <= 1'b1;
    else udf_evt[ch] <= 1'b1;
    @(posedge clock);
    match_evt <= 8'h00;
    ovf_evt <= 2'h0;
    udf_evt <= 2'h0;
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial forever #25 clock = ~clock;
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    rdc("psr0 reset", 0, A_PSR0, 32'h0);
    rdc("psr1 reset", 0, A_PSR1, 32'h0);
    apb(0, 0, 12'hffc, 32'h0, q, e);
    chk("tmr unmapped", 32'h1, {q[30:0], e});
    apb(1, 0, 12'h0f0, 32'h0, q, e);
    chk("ctl unmapped", 32'h1, {q[30:0], e});
    // pin routing: written value, read-back mask, oe and input gating
    for (int i = 0; i < 6; i++) begin
      r = xs();
      {p1, p0} = (i == 0) ? 16'hffff : r[15:0];
      wr(0, A_PSR0, {24'h0, p0});
      wr(0, A_PSR1, {24'h0, p1});
      rdc("psr0", 0, A_PSR0, {24'h0, p0 & TPS_PSR0_MASK});
      rdc("psr1", 0, A_PSR1, {24'h0, p1 & TPS_PSR1_MASK});
      wave_oe <= r[23:16];
      p2_in <= r[31:24];
      tick(5);
      chk("pin oe", route(p0, p1) & r[23:16], p2_oe);
      chk("pin in", route(p0, p1) & r[31:24], pin_to_core);
    end
    // a match while the clock enable is low leaves status untouched
    clk_en <= 1'b0;
    pulse(0, 0);
    clk_en <= 1'b1;
    rdc("stat frozen", 0, TPS_STAT0_A, 32'h0);
    // every source of both channels against a random enable
    for (int ch = 0; ch < 2; ch++) begin
      for (int s = 0; s < 6; s++) begin
        r = xs();
        wr(0, ch ? TPS_IEN1_A : TPS_IEN0_A, {26'h0, r[5:0]});
        pulse(ch, s);
        tick(2);
        chk("req", r[s], link_i.irq_req[ch]);
        chk("irq", r[s], irq);
        rdc("stat", 0, ch ? TPS_STAT1_A : TPS_STAT0_A, 32'h1 << s);
        tick(2);
        chk("req clear", 0, link_i.irq_req[ch]);
      end
    end
    // two sources stand, one enable withdrawn, then acceptance
    wr(0, TPS_IEN0_A, 32'h11);
    pulse(0, 0);
    pulse(0, 4);
    wr(0, TPS_IEN0_A, 32'h10);
    tick(2);
    chk("req held", 1, link_i.irq_req[0]);
    wr(1, TPS_IC0_A, 32'h5);
    for (int k = 0; k < 5; k++) begin
      w = (k < 4) ? cpu_v[k] : (xs() & 32'hf);
      wr(1, TPS_CPU_A, w);
      tick(3);
      chk("pending", accept(w, 3'h5), int_pending);
      if (accept(w, 3'h5)) chk("chan lvl", 32'h5, {int_channel, int_level});
    end
    // channel 1 at a higher level wins over channel 0
    wr(0, TPS_IEN1_A, 32'h1);
    pulse(1, 0);
    wr(1, TPS_CPU_A, 32'h1);
    wr(1, TPS_IC1_A, 32'h6);
    tick(2);
    chk("chan win", 32'he, {int_channel, int_level});
    rdc("stat1", 0, TPS_STAT1_A, 32'h1);
    rdc("ic0", 1, TPS_IC0_A, 32'hd);
    rdc("stat kept", 0, TPS_STAT0_A, 32'h11);
    // stop control on channel 0, its four pins routed and all pins driven
    wr(0, A_PSR0, 32'h55);
    wave_oe <= 8'hff;
    wr(0, TPS_START_A, 32'h1);
    wr(0, TPS_START_A, 32'h0);
    tick(2);
    chk("run kept", 1, count_run[0]);
    rdc("start kept", 0, TPS_START_A, 32'h1);
    r = xs();
    wave_out <= r[7:0];
    @(posedge clock);
    match_evt <= 8'h01;
    wave_out <= r[15:8];
    @(posedge clock);
    match_evt <= 8'h00;
    wave_out <= r[23:16];
    tick(3);
    chk("match stop", 0, count_run[0]);
    chk("match level", r[11:8], p2_out[3:0]);
    wr(0, TPS_START_A, 32'h1);
    wr(0, TPS_START_A, 32'h4);
    tick(2);
    chk("same write", 1, count_run[0]);
    wave_out <= r[31:24];
    tick(2);
    wr(0, TPS_START_A, 32'h4);
    wave_out <= ~r[31:24];
    tick(3);
    chk("sw stop", 0, count_run[0]);
    chk("sw level", r[27:24], p2_out[3:0]);
    for (int m = 1; m < 4; m++) begin
      r = xs();
      wr(0, TPS_FCR_A, {28'h0, r[1:0], 2'(m)});
      tick(2);
      chk("pwm level", ols(r[0], r[1]), p2_out[3:0]);
    end
    wr(0, TPS_FCR_A, 32'h0);
    // conversion triggers from back-to-back matches
    for (int k = 0; k < 2; k++) begin
      r = xs();
      if (k == 1) r[7:0] = 8'hff;
      wr(0, TPS_ADCSEL_A, {24'h0, r[7:0]});
      apb(1, 0, TPS_ADCNT_A, 32'h0, w, e);
      for (int j = 0; j < 8; j++) begin
        @(posedge clock);
        match_evt <= 8'h01 << j;
      end
      @(posedge clock);
      match_evt <= 8'h00;
      tick(3);
      rdc("adc count", 1, TPS_ADCNT_A, (w + $countones(r[7:0])) & 32'hffff);
    end
    // second reset in mid-run
    arst_n <= 1'b0;
    tick(3);
    arst_n <= 1'b1;
    rdc("psr0 again", 0, A_PSR0, 32'h0);
    wrap_up();
  end
endmodule
